/* File: verilog/bce_exec.sv */
`timescale 1ns/1ps
`include "bce_params.svh"
module bce_exec
(
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic [`BCE_INSTR_W-1:0]   instr,
  input  wire logic                      instr_valid,
  input  wire logic [`BCE_DATA_W-1:0]    file_rdata,
  input  wire logic                      acc_load,
  input  wire logic [`BCE_DATA_W-1:0]    acc_wdata,
  output logic      [`BCE_FADDR_W-1:0]   file_addr,
  output logic                           file_we,
  output logic      [`BCE_DATA_W-1:0]    file_wdata,
  output logic                           zero_we,
  output logic                           zero_val,
  output logic                           stack_push,
  output logic      [`BCE_PC_W-1:0]      stack_top_entry,
  output logic      [`BCE_PC_W-1:0]      pc,
  output logic      [`BCE_DATA_W-1:0]    acc,
  output logic                           instr_ready,
  output logic                           busy
);

  // ==========================================
  // Decode
  function automatic bce_pkg::bce_op_t bce_decode
  (
    input logic [`BCE_INSTR_W-1:0] w
  );
    bce_pkg::bce_op_t op;
    op = bce_pkg::BCE_OP_NONE;
    if (w[`BCE_TOP2_MSB:`BCE_TOP2_LSB] == `BCE_TOP2_CALL)
      op = bce_pkg::BCE_OP_CALL;
    else if (w[`BCE_ALU_MSB:`BCE_ALU_LSB] == `BCE_ALU_AND)
      op = bce_pkg::BCE_OP_AND;
    else
    begin
      case (w[`BCE_BIT_MSB:`BCE_BIT_LSB])
        `BCE_BIT_CLR: op = bce_pkg::BCE_OP_BCLR;
        `BCE_BIT_SET: op = bce_pkg::BCE_OP_BSET;
        `BCE_BIT_TSC: op = bce_pkg::BCE_OP_TSC;
        `BCE_BIT_TSS: op = bce_pkg::BCE_OP_TSS;
        default:      op = bce_pkg::BCE_OP_NONE;
      endcase
    end
    return op;
  endfunction : bce_decode

  bce_pkg::bce_state_t state_reg;
  bce_pkg::bce_state_t state_next;
  bce_pkg::bce_op_t    op;
  logic                take;
  logic [2:0]          bidx;
  logic                tbit;
  logic [`BCE_DATA_W-1:0] and_res;
  logic [`BCE_DATA_W-1:0] bmask;

  // ==========================================
  // Elaboration checks
  // Bit-op address is padded by one bit to the file address width
  if (`BCE_FADDR_W != `BCE_BADDR_W + 1)
  begin : g_faddr_chk
    $error("file address must be one bit wider than bit-op address");
  end
  // Call target fills the word below the two opcode bits
  if (`BCE_PC_W != `BCE_INSTR_W - 2)
  begin : g_pc_chk
    $error("program counter width must match the call target field");
  end
  // Mask and index logic assume an 8-bit data path
  if (`BCE_DATA_W != 8)
  begin : g_data_chk
    $error("data path must be eight bits wide");
  end

  // Instructions are only accepted in the execute state
  assign instr_ready = (state_reg == bce_pkg::BCE_ST_EXEC);
  assign busy        = !instr_ready;
  assign take        = instr_valid && instr_ready;
  assign op          = take ? bce_decode(instr) : bce_pkg::BCE_OP_NONE;
  assign bidx        = instr[`BCE_BIDX_MSB:`BCE_BIDX_LSB];
  assign bmask       = 8'h01 << bidx;
  assign tbit        = file_rdata[bidx];
  assign and_res     = acc & file_rdata;

  // ==========================================
  // File address: combinational so read data arrives same cycle
  always_comb
  begin
    if (op == bce_pkg::BCE_OP_AND)
      file_addr = instr[`BCE_FADDR_W-1:0];
    else
      file_addr = {1'b0, instr[`BCE_BADDR_W-1:0]};
  end

  // ==========================================
  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      bce_pkg::BCE_ST_EXEC:
      begin
        if ((op == bce_pkg::BCE_OP_TSC && !tbit) ||
            (op == bce_pkg::BCE_OP_TSS && tbit))
          state_next = bce_pkg::BCE_ST_NOP;
        else if (op == bce_pkg::BCE_OP_CALL)
          state_next = bce_pkg::BCE_ST_CALL2;
      end
      bce_pkg::BCE_ST_NOP:   state_next = bce_pkg::BCE_ST_EXEC;
      bce_pkg::BCE_ST_CALL2: state_next = bce_pkg::BCE_ST_EXEC;
      default:               state_next = bce_pkg::BCE_ST_EXEC;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state_reg <= bce_pkg::BCE_ST_EXEC;
    else
      state_reg <= state_next;
  end

  // ==========================================
  // Program counter
  // A skip's NOP cycle still counts, so the dropped word is stepped over
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      pc <= `BCE_PC_RST;
    else if (op == bce_pkg::BCE_OP_CALL)
      pc <= instr[`BCE_PC_W-1:0];
    else if (take || state_reg == bce_pkg::BCE_ST_NOP)
      pc <= pc + 12'h001;
  end

  // ==========================================
  // Stack push
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stack_push      <= 1'b0;
      stack_top_entry <= `BCE_PC_RST;
    end
    else
    begin
      stack_push <= (op == bce_pkg::BCE_OP_CALL);
      if (op == bce_pkg::BCE_OP_CALL)
        stack_top_entry <= pc + 12'h001;
    end
  end

  // ==========================================
  // Accumulator
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      acc <= `BCE_ACC_RST;
    else if (op == bce_pkg::BCE_OP_AND && !instr[`BCE_DEST_POS])
      acc <= and_res;
    // Loads from the rest of the core lose to an AND executed here with the accumulator as destination
    else if (acc_load)
      acc <= acc_wdata;
  end

  // ==========================================
  // File write and zero flag; bit tests write nothing
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      file_we    <= 1'b0;
      file_wdata <= 8'h00;
      zero_we    <= 1'b0;
      zero_val   <= 1'b0;
    end
    else
    begin
      file_we <= 1'b0;
      zero_we <= 1'b0;
      case (op)
        bce_pkg::BCE_OP_AND:
        begin
          file_we    <= instr[`BCE_DEST_POS];
          file_wdata <= and_res;
          zero_we    <= 1'b1;
          zero_val   <= (and_res == 8'h00);
        end
        bce_pkg::BCE_OP_BCLR:
        begin
          file_we    <= 1'b1;
          file_wdata <= file_rdata & ~bmask;
        end
        bce_pkg::BCE_OP_BSET:
        begin
          file_we    <= 1'b1;
          file_wdata <= file_rdata | bmask;
        end
        default:
        begin
          file_we <= 1'b0;
        end
      endcase
    end
  end

endmodule : bce_exec

/* File: verilog/bce_params.svh */
`ifndef BCE_PARAMS_SVH
`define BCE_PARAMS_SVH
// ==========================================
// Opcode fields
`define BCE_INSTR_W      14
`define BCE_PC_W         12
`define BCE_FADDR_W      7
`define BCE_BADDR_W      6
`define BCE_DATA_W       8
`define BCE_TOP2_MSB     13
`define BCE_TOP2_LSB     12
`define BCE_ALU_MSB      13
`define BCE_ALU_LSB      8
`define BCE_BIT_MSB      13
`define BCE_BIT_LSB      9
`define BCE_DEST_POS     7
`define BCE_BIDX_MSB     8
`define BCE_BIDX_LSB     6
`define BCE_ALU_AND      6'h05
`define BCE_TOP2_CALL    2'h2
`define BCE_BIT_CLR      5'h08
`define BCE_BIT_SET      5'h09
`define BCE_BIT_TSC      5'h0A
`define BCE_BIT_TSS      5'h0B
// ==========================================
// Reset values
`define BCE_PC_RST       12'h000
`define BCE_ACC_RST      8'h00
`endif

/* File: verilog/bce_pkg.sv */
package bce_pkg;
  typedef enum logic [2:0]
  {
    BCE_OP_NONE,
    BCE_OP_AND,
    BCE_OP_BCLR,
    BCE_OP_BSET,
    BCE_OP_TSC,
    BCE_OP_TSS,
    BCE_OP_CALL
  } bce_op_t;
  typedef enum logic [1:0]
  {
    BCE_ST_EXEC,
    BCE_ST_NOP,
    BCE_ST_CALL2
  } bce_state_t;
endpackage : bce_pkg

/* File: test/bce_exec_monitor.sv */
`timescale 1ns/1ps
// ==========================================
// Checker
module bce_exec_monitor
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [13:0] instr,
  input wire logic        instr_valid,
  input wire logic [7:0]  file_rdata,
  input wire logic [6:0]  file_addr,
  input wire logic        file_we,
  input wire logic [7:0]  file_wdata,
  input wire logic        zero_we,
  input wire logic        zero_val,
  input wire logic        stack_push,
  input wire logic [11:0] stack_top_entry,
  input wire logic [11:0] pc,
  input wire logic [7:0]  acc,
  input wire logic        instr_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire       tk    = instr_valid && instr_ready;
  wire       andop = tk && instr[13:8] == 6'h05;
  wire       bitop = tk && instr[13:11] == 3'h2;
  wire       call  = tk && instr[13:12] == 2'h2;
  wire [2:0] bi    = instr[8:6];
  wire [7:0] m     = 8'h01 << bi;
  wire       tst   = bitop && instr[10];
  wire       skp   = tst && (file_rdata[bi] == instr[9]);
  // Skip and call both stall the fetch side for exactly one cycle
  sequence s_hold;
    !instr_ready ##1 instr_ready;
  endsequence
  a_and_acc: assert property (andop && !instr[7] |=> !file_we &&
    acc == ($past(acc) & $past(file_rdata))) else $error("and acc");
  a_and_file: assert property (andop && instr[7] |=> file_we &&
    file_wdata == ($past(acc) & $past(file_rdata)) && acc == $past(acc))
    else $error("and file");
  a_and_addr: assert property (andop |-> file_addr == instr[6:0]
    ##1 instr_ready) else $error("and addr");
  a_and_zero: assert property (andop |=> zero_we && zero_val ==
    (($past(acc) & $past(file_rdata)) == 8'h00)) else $error("zero");
  a_bit_addr: assert property (bitop |->
    file_addr == {1'b0, instr[5:0]}) else $error("bit addr");
  a_bit_clear: assert property (bitop && instr[10:9] == 2'h0 |=>
    file_we && !zero_we && file_wdata == ($past(file_rdata) & ~$past(m)))
    else $error("bit clear");
  a_bit_set: assert property (bitop && instr[10:9] == 2'h1 |=>
    file_we && !zero_we && file_wdata == ($past(file_rdata) | $past(m)))
    else $error("bit set");
  a_skip_taken: assert property (skp |=>
    (!file_we && !zero_we) ##0 s_hold) else $error("skip");
  a_skip_none: assert property (tst && !skp |=>
    instr_ready && !file_we && !zero_we) else $error("no skip");
  a_call_push: assert property (call |=>
    (stack_push && !zero_we &&
    stack_top_entry == $past(pc) + 12'h001 && pc == $past(instr[11:0]))
    ##0 s_hold) else $error("call");
endmodule : bce_exec_monitor
bind bce_exec bce_exec_monitor bce_exec_monitor_inst
(
  .core_clk        (core_clk),
  .rst_b           (rst_b),
  .instr           (instr),
  .instr_valid     (instr_valid),
  .file_rdata      (file_rdata),
  .file_addr       (file_addr),
  .file_we         (file_we),
  .file_wdata      (file_wdata),
  .zero_we         (zero_we),
  .zero_val        (zero_val),
  .stack_push      (stack_push),
  .stack_top_entry (stack_top_entry),
  .pc              (pc),
  .acc             (acc),
  .instr_ready     (instr_ready)
);

/* File: test/bce_exec_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t value mismatch", $time); end end
module bce_exec_tb_top;
  logic        core_clk = 0;
  logic        rst_b = 0;
  logic        instr_valid = 0;
  logic        acc_load = 1'b0;
  logic [7:0]  acc_wdata = 8'h00;
  logic [13:0] instr = 0;
  logic [6:0]  wa, file_addr;
  logic [7:0]  mem [128], file_wdata, acc;
  logic        file_we, zero_we, zero_val, stack_push, instr_ready, busy;
  logic [11:0] stack_top_entry, pc;
  logic [13:0] tv [4] = '{14'h15C6, 14'h1606, 14'h1406, 14'h1605};
  int          n_errors = 0;
  int          check_count = 0;
  // Combinational read, write lands one cycle after the take
  wire  [7:0]  file_rdata = mem[file_addr];
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (file_we) mem[wa] <= file_wdata;
    wa <= file_addr;
  end
  bce_exec bce_exec_inst
  (
    .core_clk        (core_clk),
    .rst_b           (rst_b),
    .instr           (instr),
    .instr_valid     (instr_valid),
    .file_rdata      (file_rdata),
    .acc_load        (acc_load),
    .acc_wdata       (acc_wdata),
    .file_addr       (file_addr),
    .file_we         (file_we),
    .file_wdata      (file_wdata),
    .zero_we         (zero_we),
    .zero_val        (zero_val),
    .stack_push      (stack_push),
    .stack_top_entry (stack_top_entry),
    .pc              (pc),
    .acc             (acc),
    .instr_ready     (instr_ready),
    .busy            (busy)
  );
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic run(input logic [13:0] w);
    int n = 0;
    while (instr_ready !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
      if (n > 8) begin n_errors++; tally_and_finish(); end
    end
    instr = w;
    instr_valid = 1'b1;
    @(negedge core_clk);
  endtask : run
  task automatic stop();
    instr_valid = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : stop
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[7'h45] = 8'hC2;
    mem[7'h05] = 8'h0A;
    mem[7'h06] = 8'hC7;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    // Seed the accumulator as an earlier instruction would
    acc_load = 1'b1;
    acc_wdata = 8'h17;
    @(negedge core_clk);
    acc_load = 1'b0;
    run(14'h0545);
    `CHK(acc, 8'h02)
    `CHK(zero_we, 1'b1)
    `CHK(zero_val, 1'b0)
    run(14'h05C5);
    run(14'h13C5);
    run(14'h11C6);
    run(14'h123F);
    stop();
    `CHK(acc, 8'h02)
    `CHK(mem[7'h45], 8'h02)
    `CHK(mem[7'h05], 8'h8A)
    `CHK(mem[7'h06], 8'h47)
    `CHK(mem[7'h3F], 8'h01)
    `CHK(pc, 12'h005)
    // Two skips and two fall-throughs add six to the counter
    foreach (tv[i]) run(tv[i]);
    stop();
    `CHK(pc, 12'h00B)
    `CHK(mem[7'h06], 8'h47)
    run(14'h2FFF);
    `CHK(pc, 12'hFFF)
    `CHK(stack_top_entry, 12'h00C)
    `CHK(stack_push, 1'b1)
    `CHK(busy, 1'b1)
    run(14'h2000);
    `CHK(pc, 12'h000)
    `CHK(stack_top_entry, 12'h000)
    stop();
    tally_and_finish();
  end
endmodule : bce_exec_tb_top
